// ==== logic/cdus_current_dac.v ====
`timescale 1ns/1ns
// How it works
// RULE_01 - with update source 111 (the reset mode) every write to the high data byte loads the DAC latch.
// RULE_02 - in write-triggered mode a low-byte write is only stored and leaves the DAC output unchanged.
// RULE_03 - software wanting 10 bits writes the low byte first, then the high byte that commits the latch.
// RULE_04 - for 8-bit use software sets the low byte once and afterwards writes only the high byte.
// RULE_05 - with source 000 to 011 writes are held and a timer 0 to 3 overflow copies both bytes to the latch.
// RULE_06 - with source 100, 101, 110 a rising, falling or either pin edge copies both bytes to the latch.
// RULE_07 - the 10-bit code is left-justified: high byte holds code bits 9..2, low byte bits 7..6 hold bits 1..0.
// RULE_08 - control bits 1..0 select full scale 0.5 mA, 1 mA or 2 mA (1x), reset 2 mA, output code/1024 of it.
// RULE_09 - control bits 3..2 read as 00 and ignore writes.
// RULE_10 - the control register resets to 0x72: disabled, write-triggered, 2 mA.
// RULE_11 - control bit 7 enables the DAC; when set the pin's output driver and pull-up are off and it joins the DAC.
// RULE_12 - timer overflows are one-cycle pulses, the start pin is synchronised, and the latch loads one cycle later.
`include "cdus_regs.vh"
module cdus_current_dac (
  input wire CLOCK_I,
  input wire RST_I,
  input wire [1:0] REG_SEL_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [7:0] REG_WDATA_I,
  output reg [7:0] REG_RDATA_O,
  input wire [3:0] TIMER_OVF_I,
  input wire CONV_START_I,
  input wire GPIO_OUT_I,
  input wire GPIO_OE_I,
  input wire GPIO_PULLUP_I,
  output wire PIN_O,
  output wire PIN_OE_O,
  output wire PIN_PULLUP_O,
  output wire DAC_ENABLE_O,
  output wire [9:0] DAC_CODE_O,
  output wire [1:0] DAC_FULL_SCALE_O,
  output reg DAC_LOAD_O
);

  reg [7:0] ctrl_r;
  reg [7:0] data_high_r;
  reg [7:0] data_low_r;
  reg [9:0] latch_r;
  reg cnv_meta_r;
  reg cnv_sync_r;
  reg cnv_prev_r;
  reg [1:0] cnv_fill_r;
  reg load_pend_r;
  reg [9:0] latch_nxt;
  reg [1:0] cnv_fill_nxt;
  reg event_hit;

  wire [2:0] src;
  wire wr_ctrl;
  wire wr_high;
  wire wr_low;
  wire cnv_armed;
  wire rise;
  wire fall;

  // write strobe for one register select code
  function sel_write;
    input wr;
    input [1:0] sel;
    input [1:0] code;
    begin
      sel_write = wr && (sel == code);
    end
  endfunction

  // edge seen between the two settled samples of the start pin
  function edge_seen;
    input armed;
    input now_lvl;
    input was_lvl;
    input rising;
    begin
      if (rising) begin
        edge_seen = armed && now_lvl && !was_lvl;
      end else begin
        edge_seen = armed && !now_lvl && was_lvl;
      end
    end
  endfunction

  assign src = ctrl_r[`CDUS_SRC_MSB:`CDUS_SRC_LSB];
  assign wr_ctrl = sel_write(REG_WR_I, REG_SEL_I, `CDUS_SEL_CTRL);
  assign wr_high = sel_write(REG_WR_I, REG_SEL_I, `CDUS_SEL_HIGH);
  assign wr_low = sel_write(REG_WR_I, REG_SEL_I, `CDUS_SEL_LOW);
  // no edges until the chain holds real pin samples, so a pin idling high gives no false edge
  assign cnv_armed = (cnv_fill_r == `CDUS_SYNC_FILL);
  assign rise = edge_seen(cnv_armed, cnv_sync_r, cnv_prev_r, 1'b1); // RULE_06
  assign fall = edge_seen(cnv_armed, cnv_sync_r, cnv_prev_r, 1'b0); // RULE_06

  // left-justified packing of the two data bytes
  function [9:0] pack_code;
    input [7:0] hi;
    input [7:0] lo;
    begin
      pack_code = {hi, lo[7:6]}; // RULE_07
    end
  endfunction

  // selected update event for the current source
  always @* begin
    case (src)
      `CDUS_SRC_T0: event_hit = TIMER_OVF_I[0]; // RULE_05 RULE_12
      `CDUS_SRC_T1: event_hit = TIMER_OVF_I[1]; // RULE_05
      `CDUS_SRC_T2: event_hit = TIMER_OVF_I[2]; // RULE_05
      `CDUS_SRC_T3: event_hit = TIMER_OVF_I[3]; // RULE_05
      `CDUS_SRC_RISE: event_hit = rise; // RULE_06
      `CDUS_SRC_FALL: event_hit = fall; // RULE_06
      `CDUS_SRC_ANY: event_hit = rise || fall; // RULE_06
      `CDUS_SRC_WRITE: event_hit = wr_high; // RULE_01 RULE_02
      default: event_hit = 1'b0;
    endcase
  end

  // latch copies the stored bytes in the cycle after the event
  always @* begin
    latch_nxt = latch_r;
    if (load_pend_r) begin
      latch_nxt = pack_code(data_high_r, data_low_r); // RULE_05 RULE_06 RULE_12
    end
  end

  // fill count of the start-pin chain after reset
  always @* begin
    cnv_fill_nxt = cnv_fill_r;
    if (!cnv_armed) begin
      cnv_fill_nxt = cnv_fill_r + 2'h1;
    end
  end

  // control register; unused bits 3..2 are dropped on write
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_r <= `CDUS_CTRL_RESET; // RULE_10
    end else if (wr_ctrl) begin
      ctrl_r <= REG_WDATA_I & `CDUS_CTRL_WMASK; // RULE_09
    end
  end

  // high data byte is only stored; the latch decides when it takes effect
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      data_high_r <= 8'h00;
    end else if (wr_high) begin
      data_high_r <= REG_WDATA_I;
    end
  end

  // low data byte is only stored, never a load trigger
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      data_low_r <= 8'h00;
    end else if (wr_low) begin
      data_low_r <= REG_WDATA_I; // RULE_02
    end
  end

  // two-flop synchroniser, then one more sample for edge detection
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      cnv_meta_r <= 1'b0;
      cnv_sync_r <= 1'b0;
      cnv_prev_r <= 1'b0;
      cnv_fill_r <= 2'h0;
    end else begin
      cnv_meta_r <= CONV_START_I; // RULE_12
      cnv_sync_r <= cnv_meta_r;
      cnv_prev_r <= cnv_sync_r;
      cnv_fill_r <= cnv_fill_nxt;
    end
  end

  // one-cycle gap between the selected event and the latch load
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      load_pend_r <= 1'b0;
    end else begin
      load_pend_r <= event_hit; // RULE_12
    end
  end

  // DAC input latch
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      latch_r <= 10'h000;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // load pulse shows in the cycle the new code first stands
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      DAC_LOAD_O <= 1'b0;
    end else begin
      DAC_LOAD_O <= load_pend_r;
    end
  end

  always @* begin
    case (REG_SEL_I)
      `CDUS_SEL_CTRL: REG_RDATA_O = ctrl_r; // RULE_09
      `CDUS_SEL_HIGH: REG_RDATA_O = data_high_r;
      `CDUS_SEL_LOW: REG_RDATA_O = data_low_r;
      default: REG_RDATA_O = 8'h00;
    endcase
  end

  assign DAC_ENABLE_O = ctrl_r[`CDUS_EN_BIT]; // RULE_11
  assign DAC_CODE_O = latch_r;
  assign DAC_FULL_SCALE_O = ctrl_r[`CDUS_FS_MSB:`CDUS_FS_LSB]; // RULE_08

  // pin drive is released to the DAC while it is enabled
  function gate_pin;
    input enable;
    input value;
    begin
      gate_pin = enable ? 1'b0 : value;
    end
  endfunction

  assign PIN_O = gate_pin(DAC_ENABLE_O, GPIO_OUT_I); // RULE_11
  assign PIN_OE_O = gate_pin(DAC_ENABLE_O, GPIO_OE_I); // RULE_11
  assign PIN_PULLUP_O = gate_pin(DAC_ENABLE_O, GPIO_PULLUP_I); // RULE_11

endmodule

// ==== logic/cdus_regs.vh ====
`ifndef CDUS_REGS_VH
`define CDUS_REGS_VH
// register select codes on the special-function-register port
`define CDUS_SEL_CTRL 2'h0
`define CDUS_SEL_HIGH 2'h1
`define CDUS_SEL_LOW 2'h2
// control register fields
`define CDUS_CTRL_RESET 8'h72
`define CDUS_CTRL_WMASK 8'hf3
`define CDUS_EN_BIT 7
`define CDUS_SRC_MSB 6
`define CDUS_SRC_LSB 4
`define CDUS_FS_MSB 1
`define CDUS_FS_LSB 0
// update source codes
`define CDUS_SRC_T0 3'h0
`define CDUS_SRC_T1 3'h1
`define CDUS_SRC_T2 3'h2
`define CDUS_SRC_T3 3'h3
`define CDUS_SRC_RISE 3'h4
`define CDUS_SRC_FALL 3'h5
`define CDUS_SRC_ANY 3'h6
`define CDUS_SRC_WRITE 3'h7
// full-scale select codes
`define CDUS_FS_HALF 2'h0
`define CDUS_FS_ONE 2'h1
// start-pin samples needed before edge detection is armed
`define CDUS_SYNC_FILL 2'h3
`endif

// ==== tb/cdus_current_dac_assertions.sv ====
`timescale 1ns/1ns
module cdus_checker(input wire CLOCK_I,RST_I,REG_WR_I,CONV_START_I,PIN_OE_O,PIN_PULLUP_O,DAC_ENABLE_O,DAC_LOAD_O,
  input wire [1:0] REG_SEL_I,DAC_FULL_SCALE_O,input wire [7:0] REG_WDATA_I,REG_RDATA_O,
  input wire [3:0] TIMER_OVF_I,input wire [9:0] DAC_CODE_O);
  reg [2:0] m_r;
  // shadow of the update source field
  always @(posedge CLOCK_I or posedge RST_I)
    if (RST_I) m_r <= 3'h7;
    else if (REG_WR_I && REG_SEL_I == 2'h0) m_r <= REG_WDATA_I[6:4];
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_load; ##2 DAC_LOAD_O; endsequence
  a_high_load: assert property (REG_WR_I && REG_SEL_I == 2'h1 && m_r == 3'h7
    |-> s_load ##0 DAC_CODE_O[9:2] == $past(REG_WDATA_I, 2)) else $error("bad high load");
  a_low_held: assert property (REG_WR_I && REG_SEL_I == 2'h2 && m_r == 3'h7
    |-> ##2 !DAC_LOAD_O) else $error("low write loaded");
  a_timer_load: assert property (!m_r[2] && TIMER_OVF_I[m_r[1:0]] |-> s_load) else $error("no timer load");
  a_pin_rise: assert property (m_r == 3'h4 && $rose(CONV_START_I)
    |-> ##[3:5] DAC_LOAD_O) else $error("no edge load");
  a_pin_fall: assert property (m_r == 3'h5 && $fell(CONV_START_I)
    |-> ##[3:5] DAC_LOAD_O) else $error("no fall load");
  a_code_hold: assert property (!DAC_LOAD_O |-> $stable(DAC_CODE_O)) else $error("code moved");
  a_unused_zero: assert property (REG_SEL_I == 2'h0 |-> REG_RDATA_O[3:2] == 2'h0) else $error("unused set");
  a_scale_read: assert property (REG_SEL_I == 2'h0
    |-> REG_RDATA_O[1:0] == DAC_FULL_SCALE_O && REG_RDATA_O[7] == DAC_ENABLE_O) else $error("bad scale");
  a_pin_off: assert property (DAC_ENABLE_O |-> !PIN_OE_O && !PIN_PULLUP_O) else $error("pin driven");
endmodule
bind cdus_current_dac cdus_checker chk_u(.*);

// ==== tb/cdus_current_dac_bench.sv ====
`timescale 1ns/1ns
module current_dac_update_scheduler_bench;
  reg clk = 0, rst = 1, wr = 0, cs = 0;
  reg [1:0] sel = 0;
  reg [7:0] wd = 0;
  reg [3:0] tov = 0;
  wire [7:0] rd;
  wire [9:0] code;
  wire [1:0] fs;
  wire ld, en, pin, pin_oe, pin_pu;
  integer mismatches = 0, n_compared = 0, i;
  always #25 clk = ~clk;
  cdus_current_dac dut_u(.CLOCK_I(clk), .RST_I(rst), .REG_SEL_I(sel), .REG_WR_I(wr), .REG_RD_I(1'b0),
    .REG_WDATA_I(wd), .REG_RDATA_O(rd), .TIMER_OVF_I(tov), .CONV_START_I(cs), .GPIO_OUT_I(1'b1),
    .GPIO_OE_I(1'b1), .GPIO_PULLUP_I(1'b1), .PIN_O(pin), .PIN_OE_O(pin_oe), .PIN_PULLUP_O(pin_pu), .DAC_ENABLE_O(en),
    .DAC_CODE_O(code), .DAC_FULL_SCALE_O(fs), .DAC_LOAD_O(ld));
  task step(input integer n); begin wr = 0; repeat (n) @(posedge clk); #5; end endtask
  task w(input [1:0] s, input [7:0] d); begin sel = s; wd = d; wr = 1; @(posedge clk); #5; end endtask
  task cmp(input [8*5:1] nm, input [9:0] e, input [9:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin mismatches = mismatches + 1; $display("Error %0s expected %h seen %h", nm, e, g); end
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    step(3); rst = 0;
    cmp("ctrl", 10'h072, {2'h0, rd});
    cmp("fs", 10'h002, {8'h0, fs});
    cmp("pin", 10'h007, {6'h0, en, pin, pin_oe, pin_pu});
    w(2'h0, 8'hff); cmp("ctrl", 10'h0f3, {2'h0, rd});
    cmp("fs", 10'h003, {8'h0, fs});
    cmp("pin", 10'h008, {6'h0, en, pin, pin_oe, pin_pu});
    w(2'h2, 8'hc0); step(2); cmp("code", 10'h000, code);
    w(2'h1, 8'ha5); step(1); cmp("load", 10'h001, {9'h0, ld});
    cmp("code", 10'h297, code);
    for (i = 0; i < 4; i = i + 1) begin
      w(2'h0, {1'b0, i[2:0], 4'h1}); w(2'h1, i[7:0] + 8'h1); tov = ~(4'h1 << i); step(1); tov = 0; step(2);
      cmp("held", 10'h0, {9'h0, ld});
      tov = 4'h1 << i; step(1); tov = 0; step(1); cmp("code", {i[7:0] + 8'h1, 2'h3}, code);
    end
    for (i = 0; i < 3; i = i + 1) begin
      w(2'h0, {1'b0, 3'h4 + i[2:0], 4'h0}); w(2'h1, 8'h40 + i[7:0]); cs = ~cs; step(6);
      cmp("pin", {8'h40 + i[7:0], 2'h3}, code);
    end
    w(2'h0, 8'h72); w(2'h2, 8'h00); w(2'h1, 8'h12); step(1); cmp("code", 10'h048, code);
    w(2'h1, 8'h34); step(1); cmp("code", 10'h0d0, code);
    w(2'h2, 8'h40); w(2'h1, 8'h81); step(1); cmp("code", 10'h205, code);
    cmp("fs", 10'h002, {8'h0, fs});
    cmp("pin", 10'h007, {6'h0, en, pin, pin_oe, pin_pu});
    complete_run;
  end
endmodule
